//--- common/mtc_map.svh
// Purpose: Register indices and fixed values of the timer contention block.
// Assumes: Included by the package and the design file.
// Notes: Indices select a 16-bit register over the internal access port.
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH
`define IDX_W 5
`define IDX_GCC 5'h00
`define IDX_CAPBUF 5'h01
`define IDX_CNT1 5'h02
`define IDX_CNT2 5'h03
`define IDX_CH1A 5'h04
`define IDX_CH1B 5'h05
`define IDX_CNT3 5'h06
`define IDX_CNT4 5'h07
`define IDX_R3A 5'h08
`define IDX_R3B 5'h09
`define IDX_R3C 5'h0A
`define IDX_R3D 5'h0B
`define IDX_R4C 5'h0C
`define IDX_R4D 5'h0D
`define IDX_R4A 5'h0E
`define IDX_R4B 5'h0F
`define IDX_DEADT 5'h10
`define IDX_CDR 5'h11
`define IDX_CBR 5'h12
`define IDX_CNT0 5'h13
`define REG_COUNT 20
`define BUF_FIRST 10
`define BUF_COUNT 4
`define CNT_ALL_ONES 16'hFFFF
`define CNT_ZERO 16'h0000
`define CNT_STEP 16'h0001
`endif

//--- common/mtc_pkg.sv
// Purpose: Types shared by the timer contention block and its bench.
// Assumes: Index width comes from the map header.
// Notes: Flags are sticky; a clear vector bit drops the matching flag.
`include "mtc_map.svh"
`default_nettype none
package mtc_pkg;
	typedef enum logic [2:0] {MODE_NORMAL = 3'b001, MODE_CPWM = 3'b010, MODE_RSPWM = 3'b100} mode_e;
	typedef enum logic [1:0] {RUN_IDLE = 2'b01, RUN_COUNT = 2'b10} run_e;
	typedef struct packed {
		logic t1;
		logic t2;
		logic wr;
		logic [`IDX_W-1:0] idx;
		logic [15:0] wdata;
	} busReq_s;
	typedef struct packed {
		mode_e mode;
		logic ch3Start;
		logic ch4Start;
		logic bufA3;
		logic bufB3;
		logic bufA4;
		logic bufB4;
		logic ch3_sync_bit;
		logic ch4_sync_bit;
		logic clearOnMatch3;
		logic cascadeEn;
		logic capMode0;
		logic capBufEn0;
		logic tick0;
		logic tick2;
		logic tick3;
		logic tick4;
	} ctrl_s;
	typedef struct packed {
		logic capture0;
		logic cmp0;
		logic cmp1a;
		logic cmp1b;
		logic cmp3c;
		logic cmp3d;
		logic cmp4c;
		logic cmp4d;
		logic ovf3;
		logic ovf4;
		logic [3:0] bufCmp;
	} flags_s;
endpackage
`default_nettype wire

//--- hdl/multifunction_timer_contention.sv
// Purpose: Contention, buffering and flag behaviour of a multi-channel 16-bit timer.
// Assumes: CPU access states t1/t2 and all ticks are synchronous to mclk.
// Notes: REV_A_MASK selects the later silicon flag behaviour.
// Notes on behaviour
// - Capture during read state one returns the newly captured value.
// - Capture during write state two keeps captured value, drops CPU data.
// - Capture during buffer write state two does buffer transfer, drops CPU data.
// - Compare during write state two accepts data and still signals compare.
// - Cascade: a write to either counter wins over carry; compare on upper counter 1 still raises.
// - Complementary stop leaves counter 3 at dead time, counter 4 at zero.
// - Complementary restart resumes counting from that state without reloading.
// - Complementary buffer bit A: 3C buffers 3A, 4C buffers 4A, carrier buffer.
// - Reset-sync buffering follows channel 3 bits; channel 4 bit A silences 4C.
// - Reset-sync: channel 3 flags C and D stay clear while buffering.
// - Standard revision: channel 4 flags C and D still set while buffering.
// - A-mask revision: channel 4 flags C and D stay clear while buffering.
// - Reset-sync: channel 3 start runs both counters on channel 3 clock.
// - Standard: unsynchronized all-ones cycle clear sets channel 4 overflow, not channel 3.
// - A-mask: all-ones cycle clear sets neither overflow flag.
// - Complementary buffer flags come only from counters 3, 4 and subcounter.
// - Standard: buffer flag misses at dead-time related values.
// - A-mask: buffer flags set for every buffer value.
`include "mtc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module multifunction_timer_contention #(
	parameter bit REV_A_MASK = 1'b0
)(
	input wire logic mclk,
	input wire logic reset_n,
	input wire mtc_pkg::busReq_s bus,
	input wire mtc_pkg::ctrl_s ctrl,
	input wire logic captureEvt,
	input wire mtc_pkg::flags_s flagClear,
	output logic [15:0] readData,
	output mtc_pkg::flags_s flags,
	output logic cmpSignal0,
	output logic ch4OutC
);
	import mtc_pkg::*;

	logic [1:0] rstSync;
	logic rstN;
	logic [15:0] regs [`REG_COUNT];
	logic [15:0] next_regs [`REG_COUNT];
	flags_s next_flags;
	logic [15:0] next_readData;
	logic next_cmpSignal0;
	logic next_ch4OutC;
	run_e run;
	run_e next_run;
	logic cpwmUp;
	logic next_cpwmUp;
	logic [15:0] deadSub;
	logic [15:0] next_deadSub;
	logic [`REG_COUNT-1:0] wrSel;
	logic [`BUF_COUNT-1:0] bufHit;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			rstSync <= 2'b00;
		else
			rstSync <= {rstSync[0], 1'b1};
	end
	assign rstN = rstSync[1];

	wire logic [15:0] cnt0 = regs[`IDX_CNT0];
	wire logic [15:0] gcc = regs[`IDX_GCC];
	wire logic [15:0] cnt1 = regs[`IDX_CNT1];
	wire logic [15:0] cnt2 = regs[`IDX_CNT2];
	wire logic [15:0] cnt3 = regs[`IDX_CNT3];
	wire logic [15:0] cnt4 = regs[`IDX_CNT4];
	wire logic [15:0] r3a = regs[`IDX_R3A];
	wire logic [15:0] td = regs[`IDX_DEADT];
	wire logic cpwm = ctrl.mode == MODE_CPWM;
	wire logic rs = ctrl.mode == MODE_RSPWM;
	wire logic synced = ctrl.ch3_sync_bit && ctrl.ch4_sync_bit;
	wire logic capTake = ctrl.capMode0 && captureEvt;
	wire logic match0 = !ctrl.capMode0 && ctrl.tick0 && cnt0 == gcc;
	wire logic carry2 = ctrl.tick2 && cnt2 == `CNT_ALL_ONES;
	// Counter 4 borrows channel 3 start and clock in reset-sync mode.
	wire logic run4 = rs ? ctrl.ch3Start : ctrl.ch4Start;
	wire logic tick4 = rs ? ctrl.tick3 : ctrl.tick4;
	wire logic step3 = !cpwm && ctrl.ch3Start && ctrl.tick3;
	wire logic step4 = !cpwm && run4 && tick4;
	wire logic clr3 = step3 && ctrl.clearOnMatch3 && cnt3 == r3a;
	wire logic clr4 = clr3 && (rs || synced);
	wire logic cpwmStop = cpwm && run == RUN_COUNT && !ctrl.ch3Start;
	wire logic cpwmTick = cpwm && run == RUN_COUNT && ctrl.ch3Start && ctrl.tick3;
	wire logic cpwmTop = cpwmTick && cpwmUp && cnt3 == 16'(r3a + td);
	wire logic cpwmBottom = cpwmTick && !cpwmUp && cnt4 == `CNT_ZERO;

	genvar g;
	generate
		for (g = 0; g < `REG_COUNT; g++)
		begin : gen_wr
			assign wrSel[g] = bus.t2 && bus.wr && bus.idx == `IDX_W'(g);
		end
		for (g = 0; g < `BUF_COUNT; g++)
		begin : gen_buf
			logic [15:0] val;
			logic hit;
			logic odd;
			assign val = regs[`BUF_FIRST + g];
			assign hit = cpwmTick && (val == cnt3 || val == cnt4 || val == deadSub);
			// The older silicon misses the edge cases around dead time.
			assign odd = val == td || val == 16'(td << 1) || val == 16'(r3a - td)
				|| val == 16'(r3a - (td << 1));
			assign bufHit[g] = hit && (REV_A_MASK || !odd);
		end
	endgenerate

	always_comb
	begin
		for (int i = 0; i < `REG_COUNT; i++)
			next_regs[i] = wrSel[i] ? bus.wdata : regs[i];
		next_flags = flags_s'(flags & ~flagClear);
		next_readData = readData;
		next_cmpSignal0 = match0;
		next_ch4OutC = `CNT_ZERO == `CNT_STEP;
		next_run = (cpwm && ctrl.ch3Start) ? RUN_COUNT : RUN_IDLE;
		next_cpwmUp = cpwmUp;
		next_deadSub = deadSub;

		if (bus.t1 && !bus.wr)
		begin
			if (bus.idx == `IDX_GCC && capTake)
				next_readData = cnt0;
			else if (bus.idx < `IDX_W'(`REG_COUNT))
				next_readData = regs[bus.idx];
			else
				next_readData = `CNT_ZERO;
		end

		// A counter write in state two beats the increment.
		if (ctrl.tick0 && !wrSel[`IDX_CNT0])
			next_regs[`IDX_CNT0] = cnt0 + `CNT_STEP;
		if (match0)
			next_flags.cmp0 = 1'b1;
		if (capTake)
		begin
			next_regs[`IDX_GCC] = cnt0;
			if (ctrl.capBufEn0)
				next_regs[`IDX_CAPBUF] = gcc;
			next_flags.capture0 = 1'b1;
		end

		if (ctrl.tick2 && !wrSel[`IDX_CNT2])
			next_regs[`IDX_CNT2] = cnt2 + `CNT_STEP;
		if (ctrl.cascadeEn && carry2)
		begin
			if (!wrSel[`IDX_CNT2] && !wrSel[`IDX_CNT1])
				next_regs[`IDX_CNT1] = cnt1 + `CNT_STEP;
			if (cnt1 == regs[`IDX_CH1A])
				next_flags.cmp1a = 1'b1;
			if (cnt1 == regs[`IDX_CH1B])
				next_flags.cmp1b = 1'b1;
		end

		if (step3 && !wrSel[`IDX_CNT3])
			next_regs[`IDX_CNT3] = cnt3 + `CNT_STEP;
		if (step4 && !wrSel[`IDX_CNT4])
			next_regs[`IDX_CNT4] = cnt4 + `CNT_STEP;
		// Clearing wins over a write and an overflow, but standard unsynchronized reset-sync still sets the counter 4 overflow.
		if (clr3)
			next_regs[`IDX_CNT3] = `CNT_ZERO;
		if (clr4)
			next_regs[`IDX_CNT4] = `CNT_ZERO;
		if (step3 && cnt3 == `CNT_ALL_ONES && !wrSel[`IDX_CNT3] && !clr3)
			next_flags.ovf3 = 1'b1;
		if (step4 && cnt4 == `CNT_ALL_ONES && !wrSel[`IDX_CNT4])
		begin
			if (!clr4 || (rs && !synced && !REV_A_MASK))
				next_flags.ovf4 = 1'b1;
		end

		if (step3 && cnt3 == regs[`IDX_R3C] && !(rs && ctrl.bufA3))
			next_flags.cmp3c = 1'b1;
		if (step3 && cnt3 == regs[`IDX_R3D] && !(rs && ctrl.bufB3))
			next_flags.cmp3d = 1'b1;
		if (step4 && cnt4 == regs[`IDX_R4C] && !(rs && ctrl.bufA3 && REV_A_MASK))
			next_flags.cmp4c = 1'b1;
		if (step4 && cnt4 == regs[`IDX_R4D] && !(rs && ctrl.bufB3 && REV_A_MASK))
			next_flags.cmp4d = 1'b1;

		if (rs && clr3)
		begin
			if (ctrl.bufA3)
			begin
				next_regs[`IDX_R3A] = regs[`IDX_R3C];
				next_regs[`IDX_R4A] = regs[`IDX_R4C];
			end
			if (ctrl.bufB3)
			begin
				next_regs[`IDX_R3B] = regs[`IDX_R3D];
				next_regs[`IDX_R4B] = regs[`IDX_R4D];
			end
		end
		if (rs && !ctrl.bufA4)
		begin
			// Output 4C rises at the cycle clear and falls on its duty match.
			if (clr3)
				next_ch4OutC = 1'b1;
			else if (step4 && cnt4 == regs[`IDX_R4A])
				next_ch4OutC = 1'b0;
			else
				next_ch4OutC = ch4OutC;
		end

		if (cpwmStop)
		begin
			next_regs[`IDX_CNT3] = td;
			next_regs[`IDX_CNT4] = `CNT_ZERO;
			next_cpwmUp = 1'b1;
			next_deadSub = td;
		end
		else if (cpwmTick)
		begin
			if (cpwmTop)
			begin
				next_cpwmUp = 1'b0;
				next_deadSub = td;
				if (ctrl.bufA3)
				begin
					next_regs[`IDX_R3A] = regs[`IDX_R3C];
					next_regs[`IDX_R4A] = regs[`IDX_R4C];
					next_regs[`IDX_CDR] = regs[`IDX_CBR];
				end
				if (ctrl.bufB3)
				begin
					next_regs[`IDX_R3B] = regs[`IDX_R3D];
					next_regs[`IDX_R4B] = regs[`IDX_R4D];
				end
			end
			else if (cpwmBottom)
			begin
				next_cpwmUp = 1'b1;
				next_deadSub = td;
				next_flags.ovf4 = 1'b1;
			end
			else
			begin
				if (!wrSel[`IDX_CNT3])
					next_regs[`IDX_CNT3] = cpwmUp ? cnt3 + `CNT_STEP : cnt3 - `CNT_STEP;
				if (!wrSel[`IDX_CNT4])
					next_regs[`IDX_CNT4] = cpwmUp ? cnt4 + `CNT_STEP : cnt4 - `CNT_STEP;
				if (deadSub != `CNT_ZERO)
					next_deadSub = deadSub - `CNT_STEP;
			end
		end
		next_flags.bufCmp = next_flags.bufCmp | bufHit;
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			for (int i = 0; i < `REG_COUNT; i++)
				regs[i] <= `CNT_ZERO;
			flags <= '0;
			readData <= `CNT_ZERO;
			cmpSignal0 <= 1'b0;
			ch4OutC <= 1'b0;
			run <= RUN_IDLE;
			cpwmUp <= 1'b1;
			deadSub <= `CNT_ZERO;
		end
		else
		begin
			for (int i = 0; i < `REG_COUNT; i++)
				regs[i] <= next_regs[i];
			flags <= next_flags;
			readData <= next_readData;
			cmpSignal0 <= next_cmpSignal0;
			ch4OutC <= next_ch4OutC;
			run <= next_run;
			cpwmUp <= next_cpwmUp;
			deadSub <= next_deadSub;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstN);

	sequence capRead;
		bus.t1 && !bus.wr && bus.idx == `IDX_GCC && capTake;
	endsequence
	sequence cpwmHalt;
		cpwmStop ##1 (!ctrl.ch3Start && !wrSel[`IDX_CNT3] && !wrSel[`IDX_CNT4]);
	endsequence
	sequence rsAllOnesClear;
		rs && clr3 && r3a == `CNT_ALL_ONES && !synced && step4 && cnt4 == `CNT_ALL_ONES
			&& !wrSel[`IDX_CNT4] && !flags.ovf3 && !flags.ovf4 && !flagClear.ovf4;
	endsequence

	chk_capture_read_new: assert property (capRead |=> readData == $past(cnt0))
		else $error("Read during capture returned stale data.");
	chk_capture_beats_write: assert property (wrSel[`IDX_GCC] && capTake
		|=> gcc == $past(cnt0))
		else $error("CPU write overrode a capture.");
	chk_buffer_beats_write: assert property (wrSel[`IDX_CAPBUF] && capTake && ctrl.capBufEn0
		|=> regs[`IDX_CAPBUF] == $past(gcc))
		else $error("CPU write overrode a buffer transfer.");
	chk_write_with_match: assert property (wrSel[`IDX_GCC] && match0
		|=> gcc == $past(bus.wdata) && cmpSignal0 && flags.cmp0)
		else $error("Compare during write lost data or signal.");
	chk_cascade_write_wins: assert property (ctrl.cascadeEn && carry2 && wrSel[`IDX_CNT2]
		&& !wrSel[`IDX_CNT1] |=> cnt2 == $past(bus.wdata) && $stable(cnt1))
		else $error("Cascade carry not suppressed by write.");
	chk_cpwm_stop_hold: assert property (cpwmHalt |-> cnt3 == $past(td, 1) && cnt4 == `CNT_ZERO
		&& run == RUN_IDLE)
		else $error("Counters not initialized on complementary stop.");
	chk_cpwm_top_transfer: assert property (cpwmTop && ctrl.bufA3 && !wrSel[`IDX_R3A]
		|=> r3a == $past(regs[`IDX_R3C]) && regs[`IDX_CDR] == $past(regs[`IDX_CBR]))
		else $error("Complementary buffer transfer missing.");
	chk_ch4c_silenced: assert property (rs && ctrl.bufA4 |=> !ch4OutC)
		else $error("Output 4C driven while its buffer bit is set.");
	chk_rs_ch3_flag_quiet: assert property (rs && ctrl.bufA3 && !flags.cmp3c
		|=> !flags.cmp3c)
		else $error("Channel 3 flag C set while buffering.");
	chk_rs_ch4_flag_rev: assert property (rs && ctrl.bufA3 && step4 && cnt4 == regs[`IDX_R4C]
		&& !flags.cmp4c |=> flags.cmp4c == !REV_A_MASK)
		else $error("Channel 4 flag C wrong for this revision.");
	chk_rs_overflow_rev: assert property (rsAllOnesClear
		|=> !flags.ovf3 && flags.ovf4 == !REV_A_MASK)
		else $error("Overflow flags wrong at all-ones cycle clear.");
	chk_rs_counts_together: assert property (rs && ctrl.ch3Start && ctrl.tick3 && !clr3
		&& !wrSel[`IDX_CNT3] && !wrSel[`IDX_CNT4]
		|=> cnt3 == 16'($past(cnt3) + `CNT_STEP) && cnt4 == 16'($past(cnt4) + `CNT_STEP))
		else $error("Counters 3 and 4 not stepping together.");
endmodule
`default_nettype wire

//--- verif/cpu_bus_model.sv
// Purpose: CPU bus master that runs two-state read and write cycles.
// Assumes: Requests change just after a rising edge of mclk.
// Notes: The evt output marks the state that a coincident timer event must hit.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
(
	input wire logic mclk,
	input wire logic [15:0] readData,
	output mtc_pkg::busReq_s bus,
	output logic evt
);
	import mtc_pkg::*;
	logic [15:0] lastData = 16'h0000;
	initial
	begin
		bus = '0;
		evt = 1'b0;
	end
	// An idle bus shows inverted data so that a stale word never looks valid.
	task automatic idle(input logic [4:0] idx);
		bus <= '{1'b0, 1'b0, 1'b0, idx, ~lastData};
	endtask
	// A read is taken in state one, so the event is placed there.
	task automatic rd(input logic [4:0] idx, input logic e, output logic [15:0] d);
		@(posedge mclk);
		bus <= '{1'b1, 1'b0, 1'b0, idx, ~lastData};
		evt <= e;
		@(posedge mclk);
		bus <= '{1'b0, 1'b1, 1'b0, idx, ~lastData};
		evt <= 1'b0;
		@(posedge mclk);
		idle(idx);
		d = readData;
	endtask
	// A write is taken in state two, so the event is placed there.
	task automatic wr(input logic [4:0] idx, input logic [15:0] v, input logic e);
		@(posedge mclk);
		bus <= '{1'b1, 1'b0, 1'b1, idx, v};
		@(posedge mclk);
		bus <= '{1'b0, 1'b1, 1'b1, idx, v};
		evt <= e;
		@(posedge mclk);
		lastData = v;
		idle(idx);
		evt <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- verif/test_multifunction_timer_contention.sv
// Purpose: Self-checking bench of the timer contention block.
// Assumes: Standard revision; the CPU model owns the access bus.
// Notes: Event routing picks which input a coincident event pulses.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errTotal++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_multifunction_timer_contention;
	import mtc_pkg::*;
	typedef struct {logic [4:0] idx; logic [15:0] wv; logic [15:0] ev;} row_t;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] evSel = 2'h0;
	ctrl_s ctrlReg;
	ctrl_s ctrlIn;
	flags_s flagClear;
	flags_s flags;
	busReq_s bus;
	logic evt;
	logic captureEvt;
	logic [15:0] readData;
	logic [15:0] rdv;
	logic cmpSignal0;
	logic ch4OutC;
	int errTotal = 0;
	int checksDone = 0;
	int cycles = 0;
	row_t rows[$] = '{'{5'h00, 16'h1234, 16'h1234}, '{5'h02, 16'h2345, 16'h2345},
		'{5'h04, 16'hA5A5, 16'hA5A5}, '{5'h08, 16'h0F0F, 16'h0F0F}, '{5'h0E, 16'h4A4A, 16'h4A4A},
		'{5'h10, 16'h0003, 16'h0003}, '{5'h13, 16'h3C3C, 16'h3C3C}, '{5'h1F, 16'h7777, 16'h0000}};
	always #50 mclk = ~mclk;
	assign captureEvt = evt & (evSel == 2'h0);
	always_comb
	begin
		ctrlIn = ctrlReg;
		ctrlIn.tick0 = ctrlReg.tick0 | (evt & (evSel == 2'h1));
		ctrlIn.tick2 = ctrlReg.tick2 | (evt & (evSel == 2'h2));
	end
	multifunction_timer_contention dut
	(
		.mclk(mclk), .reset_n(reset_n), .bus(bus), .ctrl(ctrlIn), .captureEvt(captureEvt),
		.flagClear(flagClear), .readData(readData), .flags(flags), .cmpSignal0(cmpSignal0),
		.ch4OutC(ch4OutC)
	);
	cpu_bus_model cpu
	(
		.mclk(mclk), .readData(readData), .bus(bus), .evt(evt)
	);
	task automatic tallyAndFinish();
		$display("Comparisons %0d, mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic runCh3(input int n);
		ctrlReg.ch3Start <= 1'b1;
		ctrlReg.tick3 <= 1'b1;
		repeat (n) @(posedge mclk);
		ctrlReg.ch3Start <= 1'b0;
		ctrlReg.tick3 <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic loadAllOnes();
		flagClear <= '1;
		cpu.wr(5'h08, 16'hFFFF, 1'b0);
		flagClear <= '0;
		cpu.wr(5'h06, 16'hFFFD, 1'b0);
		cpu.wr(5'h07, 16'hFFFD, 1'b0);
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			errTotal++;
			$display("unexpected at %0t: run did not complete", $time);
			tallyAndFinish();
		end
	end
	initial
	begin
		flagClear = '0;
		ctrlReg = '0;
		ctrlReg.mode = MODE_NORMAL;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		`CHK(flags, flags_s'(0))
		`CHK(readData, 16'h0000)
		foreach (rows[i])
			cpu.wr(rows[i].idx, rows[i].wv, 1'b0);
		foreach (rows[i])
		begin
			cpu.rd(rows[i].idx, 1'b0, rdv);
			`CHK(rdv, rows[i].ev)
		end
		ctrlReg.capMode0 <= 1'b1;
		cpu.wr(5'h13, 16'h0077, 1'b0);
		cpu.rd(5'h00, 1'b1, rdv);
		`CHK(rdv, 16'h0077)
		cpu.wr(5'h13, 16'h0088, 1'b0);
		cpu.wr(5'h00, 16'h5555, 1'b1);
		cpu.rd(5'h00, 1'b0, rdv);
		`CHK(rdv, 16'h0088)
		`CHK(flags.capture0, 1'b1)
		ctrlReg.capBufEn0 <= 1'b1;
		cpu.wr(5'h13, 16'h0099, 1'b0);
		cpu.wr(5'h01, 16'h6666, 1'b1);
		cpu.rd(5'h01, 1'b0, rdv);
		`CHK(rdv, 16'h0088)
		ctrlReg.capMode0 <= 1'b0;
		ctrlReg.capBufEn0 <= 1'b0;
		evSel <= 2'h1;
		cpu.wr(5'h13, 16'h0040, 1'b0);
		cpu.wr(5'h00, 16'h0040, 1'b0);
		cpu.wr(5'h00, 16'h0055, 1'b1);
		#1;
		`CHK(cmpSignal0, 1'b1)
		`CHK(flags.cmp0, 1'b1)
		cpu.rd(5'h00, 1'b0, rdv);
		`CHK(rdv, 16'h0055)
		evSel <= 2'h2;
		// A cascade carry meets a counter 2 write; counter 1 holds and its compare A still sets.
		ctrlReg.cascadeEn <= 1'b1;
		cpu.wr(5'h03, 16'hFFFF, 1'b0);
		cpu.wr(5'h02, 16'h0010, 1'b0);
		cpu.wr(5'h04, 16'h0010, 1'b0);
		cpu.wr(5'h03, 16'h0005, 1'b1);
		cpu.rd(5'h03, 1'b0, rdv);
		`CHK(rdv, 16'h0005)
		cpu.rd(5'h02, 1'b0, rdv);
		`CHK(rdv, 16'h0010)
		`CHK(flags.cmp1a, 1'b1)
		ctrlReg.cascadeEn <= 1'b0;
		ctrlReg.mode <= MODE_CPWM;
		ctrlReg.bufA3 <= 1'b1;
		cpu.wr(5'h10, 16'h0004, 1'b0);
		// A buffer value of one dead time must never raise its flag on this revision.
		cpu.wr(5'h0B, 16'h0004, 1'b0);
		cpu.wr(5'h08, 16'h0006, 1'b0);
		runCh3(12);
		cpu.rd(5'h06, 1'b0, rdv);
		`CHK(rdv, 16'h0004)
		cpu.rd(5'h07, 1'b0, rdv);
		`CHK(rdv, 16'h0000)
		cpu.rd(5'h08, 1'b0, rdv);
		`CHK(rdv, 16'h0000)
		`CHK(flags.bufCmp, 4'hD)
		cpu.wr(5'h08, 16'h0006, 1'b0);
		ctrlReg.ch3Start <= 1'b1;
		ctrlReg.tick3 <= 1'b1;
		repeat (2) @(posedge mclk);
		ctrlReg.tick3 <= 1'b0;
		cpu.rd(5'h06, 1'b0, rdv);
		`CHK(rdv, 16'h0005)
		cpu.rd(5'h07, 1'b0, rdv);
		`CHK(rdv, 16'h0001)
		ctrlReg.ch3Start <= 1'b0;
		// Channel 4 buffer bits stay low and both counters are loaded first.
		ctrlReg.mode <= MODE_RSPWM;
		ctrlReg.clearOnMatch3 <= 1'b1;
		ctrlReg.bufB3 <= 1'b1;
		cpu.wr(5'h0B, 16'h0000, 1'b0);
		loadAllOnes();
		runCh3(6);
		`CHK(flags.ovf4, 1'b1)
		`CHK(flags.ovf3, 1'b0)
		`CHK({flags.cmp3c, flags.cmp3d}, 2'h0)
		// On the standard revision, channel 4 flags C and D still set while buffering.
		`CHK({flags.cmp4c, flags.cmp4d}, 2'h3)
		`CHK(ch4OutC, 1'b1)
		ctrlReg.bufA4 <= 1'b1;
		repeat (2) @(posedge mclk);
		`CHK(ch4OutC, 1'b0)
		// Synchronized clearing of channels 3 and 4 keeps both overflow flags quiet.
		ctrlReg.bufA4 <= 1'b0;
		ctrlReg.bufA3 <= 1'b0;
		ctrlReg.bufB3 <= 1'b0;
		ctrlReg.ch3_sync_bit <= 1'b1;
		ctrlReg.ch4_sync_bit <= 1'b1;
		loadAllOnes();
		runCh3(6);
		`CHK({flags.ovf3, flags.ovf4}, 2'h0)
		tallyAndFinish();
	end
endmodule
`default_nettype wire
